// ### rtl/amh_defs.svh
// register offsets, reset values and timing constants of the axis sequencer
`ifndef AMH_DEFS_SVH
`define AMH_DEFS_SVH
`define AMH_OFF_CTRL 8'h00
`define AMH_OFF_TARGET 8'h04
`define AMH_OFF_VEL 8'h08
`define AMH_OFF_ACC 8'h0C
`define AMH_OFF_JOG_HI 8'h10
`define AMH_OFF_JOG_LO 8'h14
`define AMH_OFF_HOME_VEL 8'h18
`define AMH_OFF_LIM_LO 8'h1C
`define AMH_OFF_LIM_HI 8'h20
`define AMH_OFF_STATUS 8'h24
`define AMH_OFF_POS 8'h28
`define AMH_OFF_FERR 8'h2C
`define AMH_OFF_DPOS 8'h30
`define AMH_CTRL_MOVE 0
`define AMH_CTRL_REL 1
`define AMH_CTRL_HOME 2
`define AMH_CTRL_STOP 3
`define AMH_RST_VEL 32'h0000_0064
`define AMH_RST_ACC 32'h0000_000A
`define AMH_RST_JOG_HI 32'h0000_0032
`define AMH_RST_JOG_LO 32'h0000_0005
`define AMH_RST_HOME_VEL 32'h0000_0028
`define AMH_RST_LIM_LO 32'h8000_0000
`define AMH_RST_LIM_HI 32'h7FFF_FFFF
`define AMH_JOG_ACC_DIV 32'h0000_000A
`define AMH_HOME_SLOW_DIV 32'h0000_000A
`define AMH_RESP_OKAY 2'h0
`define AMH_RESP_SLVERR 2'h2
`define AMH_SERVO_US 400
`define AMH_CLK_MHZ 200
`define AMH_SERVO_CYCLES (`AMH_SERVO_US * `AMH_CLK_MHZ)
`endif

// ### rtl/amh_pkg.sv
// types shared by the axis sequencer
package amh_pkg;
  typedef logic [31:0] amh_word_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_MOVE, ST_JOG,
    ST_HA, ST_HA_STOP, ST_HB, ST_HB_STOP, ST_HC, ST_HC_STOP, ST_HD, ST_HE
  } amh_state_t;
endpackage

// ### rtl/amh_axis_seq.sv
// axis motion, jog, quadrature counter and home sequencer with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "amh_defs.svh"
// Summary of operation
// [RULE_01] see move ramps, cruises, brakes onto target
// [RULE_02] see target absolute or relative to start
// [RULE_03] see velocity, acceleration changes apply mid-move
// [RULE_04] see jog runs only while button held
// [RULE_05] see separate programmable high and low jog speeds
// [RULE_06] see jog acceleration is acceleration over ten
// [RULE_07] see position counter follows encoder, reset zero
// [RULE_08] see four counts per encoder cycle
// [RULE_09] see encoder gives square quadrature channels
// [RULE_10] see origin level picks first search direction
// [RULE_11] see first index after transition sets zero
// [RULE_12] see far side starts with segment A
// [RULE_13] see B at home speed, C at half
// [RULE_14] see D and E at one tenth
// [RULE_15] see D flows into E without stop
// [RULE_16] see segment E always runs positive
// [RULE_17] see display refresh suppressed during E
// [RULE_18] see no commands during home except stop
// [RULE_19] see following error formed each servo period
// [RULE_20] see sequencer state tracks segment, done flag
// [RULE_21] see software limits stop commanded motion
module amh_axis_seq #(
  parameter int SERVO_CYCLES = `AMH_SERVO_CYCLES,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire amh_pkg::amh_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output amh_pkg::amh_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // encoder, origin switch, jog buttons
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic origin_sw,
  input wire logic jog_fwd,
  input wire logic jog_rev,
  input wire logic jog_fast,
  // status toward control loop and panel
  output amh_pkg::amh_word_t follow_err,
  output logic busy,
  output logic home_done,
  output logic disp_suppress
);
  import amh_pkg::*;

  amh_state_t state;
  amh_word_t target, vel, acc, jog_hi, jog_lo, home_vel, lim_lo, lim_hi;
  amh_word_t pos, dpos, goal, spd;
  logic dir, lim_hit, move_go, move_rel, home_go, stop_go;
  logic a_q, a_p, b_q, b_p, idx_q, idx_p, org_q, org_p;
  logic [31:0] tick_cnt;
  logic tick, step_one, fwd_step, rev_step, idx_hit, org_rise, org_fall;

  function automatic amh_word_t ramp(amh_word_t cur, amh_word_t tgt, amh_word_t a);
    if (cur < tgt) begin
      ramp = (tgt - cur > a) ? cur + a : tgt;
    end else begin
      ramp = (cur - tgt > a) ? cur - a : tgt;
    end
  endfunction

  function automatic amh_word_t wmerge(amh_word_t old, amh_word_t d, logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        old[8*i +: 8] = d[8*i +: 8];
      end
    end
    wmerge = old;
  endfunction

  // servo period tick
  assign tick = (tick_cnt == 32'(SERVO_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // input registers and edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {a_q, a_p, b_q, b_p, idx_q, idx_p, org_q, org_p} <= 8'h00;
    end else begin
      {a_q, b_q, idx_q, org_q} <= {enc_a, enc_b, enc_index, origin_sw};
      {a_p, b_p, idx_p, org_p} <= {a_q, b_q, idx_q, org_q};
    end
  end
  assign step_one = (a_q ^ a_p) ^ (b_q ^ b_p);
  assign fwd_step = step_one & (a_p ^ b_q); // see [RULE_08] [RULE_09]
  assign rev_step = step_one & ~(a_p ^ b_q);
  assign idx_hit = (state == ST_HE) && idx_q && !idx_p; // see [RULE_11]
  assign org_rise = org_q && !org_p;
  assign org_fall = !org_q && org_p;

  // position counter, cleared at reset and at the home index
  always_ff @(posedge aclk) begin
    if (!aresetn || idx_hit) begin
      pos <= 32'h0000_0000; // see [RULE_07] [RULE_11]
    end else if (fwd_step) begin
      pos <= pos + 32'h0000_0001; // see [RULE_07]
    end else if (rev_step) begin
      pos <= pos - 32'h0000_0001;
    end
  end

  // profile arithmetic
  amh_word_t acc1, jacc, rem, mv_spd, seg_tgt, seg_acc, step, nxt, hs;
  logic [63:0] brake_lhs, brake_rhs;
  logic arrive, over_lim;
  always_comb begin
    acc1 = (acc == 32'h0000_0000) ? 32'h0000_0001 : acc;
    jacc = acc1 / `AMH_JOG_ACC_DIV; // see [RULE_06]
    if (jacc == 32'h0000_0000) begin
      jacc = 32'h0000_0001;
    end
    hs = home_vel / `AMH_HOME_SLOW_DIV; // see [RULE_14]
    if (hs == 32'h0000_0000) begin
      hs = 32'h0000_0001;
    end
    rem = dir ? goal - dpos : dpos - goal;
    brake_lhs = ({32'h0000_0000, acc1} * {32'h0000_0000, rem}) << 1;
    brake_rhs = {32'h0000_0000, spd} * ({32'h0000_0000, spd} + {32'h0000_0000, acc1});
    // see [RULE_01] [RULE_03] brake once stopping distance reaches remainder
    mv_spd = (brake_lhs <= brake_rhs) ? ramp(spd, 32'h0000_0000, acc1) : ramp(spd, vel, acc1);
    if (mv_spd == 32'h0000_0000) begin
      mv_spd = 32'h0000_0001;
    end
    arrive = mv_spd >= rem;
    seg_acc = acc1;
    case (state)
      ST_JOG: begin
        seg_tgt = jog_fast ? jog_hi : jog_lo; // see [RULE_05]
        seg_acc = jacc;
      end
      ST_HA, ST_HB: seg_tgt = home_vel; // see [RULE_12] [RULE_13]
      ST_HC: seg_tgt = home_vel >> 1; // see [RULE_13]
      ST_HD, ST_HE: seg_tgt = hs; // see [RULE_14]
      default: seg_tgt = 32'h0000_0000;
    endcase
    step = (state == ST_MOVE) ? mv_spd : ramp(spd, seg_tgt, seg_acc);
    nxt = dir ? dpos + step : dpos - step;
    over_lim = dir ? ($signed(nxt) > $signed(lim_hi)) || ($signed(pos) > $signed(lim_hi))
                   : ($signed(nxt) < $signed(lim_lo)) || ($signed(pos) < $signed(lim_lo));
  end

  // motion and home sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      spd <= 32'h0000_0000;
      dpos <= 32'h0000_0000;
      goal <= 32'h0000_0000;
      dir <= 1'b1;
      home_done <= 1'b0;
      lim_hit <= 1'b0;
    end else if (stop_go) begin
      state <= ST_IDLE;
      spd <= 32'h0000_0000;
    end else begin
      if (tick && state != ST_IDLE && state != ST_MOVE && state != ST_JOG) begin
        spd <= step;
        dpos <= nxt;
      end
      case (state)
        ST_IDLE: begin
          spd <= 32'h0000_0000;
          if (move_go) begin
            goal <= move_rel ? dpos + target : target; // see [RULE_02]
            dir <= move_rel ? !target[31] : ($signed(target) >= $signed(dpos));
            lim_hit <= 1'b0;
            state <= ST_MOVE;
          end else if (home_go) begin
            home_done <= 1'b0;
            dir <= !org_q; // see [RULE_10]
            state <= org_q ? ST_HA : ST_HB; // see [RULE_12]
          end else if (jog_fwd || jog_rev) begin
            dir <= jog_fwd;
            lim_hit <= 1'b0;
            state <= ST_JOG;
          end
        end
        ST_MOVE: begin
          if (tick) begin
            if (over_lim) begin
              lim_hit <= 1'b1; // see [RULE_21]
              spd <= 32'h0000_0000;
              state <= ST_IDLE;
            end else if (arrive) begin
              dpos <= goal; // see [RULE_01]
              spd <= 32'h0000_0000;
              state <= ST_IDLE;
            end else begin
              spd <= step;
              dpos <= nxt;
            end
          end
        end
        ST_JOG: begin
          if (!jog_fwd && !jog_rev) begin
            spd <= 32'h0000_0000; // see [RULE_04]
            state <= ST_IDLE;
          end else if (tick) begin
            if (over_lim) begin
              lim_hit <= 1'b1; // see [RULE_21]
              spd <= 32'h0000_0000;
              state <= ST_IDLE;
            end else begin
              spd <= step; // see [RULE_04]
              dpos <= nxt;
            end
          end
        end
        ST_HA: if (org_fall) state <= ST_HA_STOP; // see [RULE_20]
        ST_HA_STOP: if (spd == 32'h0000_0000) begin
          dir <= 1'b1;
          state <= ST_HB;
        end
        ST_HB: if (org_rise) state <= ST_HB_STOP; // see [RULE_13]
        ST_HB_STOP: if (spd == 32'h0000_0000) begin
          dir <= 1'b0;
          state <= ST_HC;
        end
        ST_HC: if (org_fall) state <= ST_HC_STOP; // see [RULE_14]
        ST_HC_STOP: if (spd == 32'h0000_0000) begin
          dir <= 1'b1; // see [RULE_16]
          state <= ST_HD;
        end
        ST_HD: if (org_rise) state <= ST_HE; // see [RULE_15]
        ST_HE: if (idx_hit) begin
          dpos <= 32'h0000_0000; // see [RULE_11]
          spd <= 32'h0000_0000;
          home_done <= 1'b1; // see [RULE_20]
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // following error and status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      follow_err <= 32'h0000_0000;
      busy <= 1'b0;
      disp_suppress <= 1'b0;
    end else begin
      if (tick) begin
        follow_err <= dpos - pos; // see [RULE_19]
      end
      busy <= (state != ST_IDLE);
      disp_suppress <= (state == ST_HE); // see [RULE_17]
    end
  end

  // axi4-lite write channel and registers
  logic wr_fire, wr_ok, rd_ok;
  amh_word_t rd_mux;
  assign wr_fire = awready && awvalid && wready && wvalid;
  always_comb begin
    case (awaddr)
      `AMH_OFF_CTRL, `AMH_OFF_TARGET, `AMH_OFF_VEL, `AMH_OFF_ACC, `AMH_OFF_JOG_HI,
      `AMH_OFF_JOG_LO, `AMH_OFF_HOME_VEL, `AMH_OFF_LIM_LO, `AMH_OFF_LIM_HI: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `AMH_RESP_OKAY;
      {move_go, move_rel, home_go, stop_go} <= 4'h0;
      target <= 32'h0000_0000;
      vel <= `AMH_RST_VEL;
      acc <= `AMH_RST_ACC;
      jog_hi <= `AMH_RST_JOG_HI;
      jog_lo <= `AMH_RST_JOG_LO;
      home_vel <= `AMH_RST_HOME_VEL;
      lim_lo <= `AMH_RST_LIM_LO;
      lim_hi <= `AMH_RST_LIM_HI;
    end else begin
      awready <= !awready && awvalid && wvalid && !bvalid;
      wready <= !awready && awvalid && wvalid && !bvalid;
      {move_go, home_go, stop_go} <= 3'h0;
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `AMH_RESP_OKAY : `AMH_RESP_SLVERR;
        case (awaddr)
          `AMH_OFF_CTRL: if (wstrb[0]) begin
            move_go <= wdata[`AMH_CTRL_MOVE];
            move_rel <= wdata[`AMH_CTRL_REL];
            home_go <= wdata[`AMH_CTRL_HOME];
            stop_go <= wdata[`AMH_CTRL_STOP];
          end
          `AMH_OFF_TARGET: target <= wmerge(target, wdata, wstrb);
          `AMH_OFF_VEL: vel <= wmerge(vel, wdata, wstrb); // see [RULE_03]
          `AMH_OFF_ACC: acc <= wmerge(acc, wdata, wstrb); // see [RULE_03]
          `AMH_OFF_JOG_HI: jog_hi <= wmerge(jog_hi, wdata, wstrb); // see [RULE_05]
          `AMH_OFF_JOG_LO: jog_lo <= wmerge(jog_lo, wdata, wstrb); // see [RULE_05]
          `AMH_OFF_HOME_VEL: home_vel <= wmerge(home_vel, wdata, wstrb);
          `AMH_OFF_LIM_LO: lim_lo <= wmerge(lim_lo, wdata, wstrb); // see [RULE_21]
          `AMH_OFF_LIM_HI: lim_hi <= wmerge(lim_hi, wdata, wstrb);
          default: ;
        endcase
      end
    end
  end

  // axi4-lite read channel
  always_comb begin
    rd_ok = 1'b1;
    case (araddr)
      `AMH_OFF_CTRL: rd_mux = 32'h0000_0000;
      `AMH_OFF_TARGET: rd_mux = target;
      `AMH_OFF_VEL: rd_mux = vel;
      `AMH_OFF_ACC: rd_mux = acc;
      `AMH_OFF_JOG_HI: rd_mux = jog_hi;
      `AMH_OFF_JOG_LO: rd_mux = jog_lo;
      `AMH_OFF_HOME_VEL: rd_mux = home_vel;
      `AMH_OFF_LIM_LO: rd_mux = lim_lo;
      `AMH_OFF_LIM_HI: rd_mux = lim_hi;
      `AMH_OFF_STATUS: rd_mux = {25'h000_0000, lim_hit, home_done, (state != ST_IDLE), state};
      `AMH_OFF_POS: rd_mux = pos;
      `AMH_OFF_FERR: rd_mux = follow_err;
      `AMH_OFF_DPOS: rd_mux = dpos;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AMH_RESP_OKAY;
    end else begin
      arready <= !arready && arvalid && !rvalid;
      if (arready && arvalid) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? `AMH_RESP_OKAY : `AMH_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_d_found;
    (state == ST_HD) && org_rise && !stop_go;
  endsequence

  enc_fwd_count_a: assert property (fwd_step && !idx_hit |=> pos == $past(pos) + 1) // see [RULE_07]
    else $error("forward encoder step not counted");
  enc_rev_count_a: assert property (rev_step && !idx_hit |=> pos == $past(pos) - 1) // see [RULE_08]
    else $error("reverse encoder step not counted");
  jog_release_a: assert property (state == ST_JOG && !jog_fwd && !jog_rev |=> spd == 0) // see [RULE_04]
    else $error("jog did not stop on release");
  ferr_tick_a: assert property (tick |=> follow_err == $past(dpos) - $past(pos)) // see [RULE_19]
    else $error("following error not formed at servo tick");
  seg_e_dir_a: assert property (state == ST_HE |-> dir) // see [RULE_16]
    else $error("segment E not positive");
  disp_supp_a: assert property (state == ST_HE |=> disp_suppress) // see [RULE_17]
    else $error("display not suppressed in segment E");
  index_ref_a: assert property (idx_hit && !stop_go |=> home_done && pos == 0 && state == ST_IDLE) // see [RULE_11]
    else $error("index capture failed");
  d_to_e_a: assert property (s_d_found |=> state == ST_HE) // see [RULE_15]
    else $error("stop between segments D and E");
  home_start_a: assert property (state == ST_IDLE && home_go && !stop_go && !move_go
    |=> state == (org_p ? ST_HA : ST_HB) && dir == !org_p) // see [RULE_10]
    else $error("wrong first home segment");
  wr_resp_a: assert property (wr_fire |=> bvalid ##0 bvalid [*1] ##1 (bvalid || $past(bready)))
    else $error("write response lost");
endmodule

// ### sim/amh_enc_model.sv
// encoder, origin switch and index model that follows the sequencer's error
`timescale 1ns/1ps
module amh_enc_model #(
  parameter int SC = 40,
  parameter int ORG = 200,
  parameter int IPER = 64,
  parameter int IOFF = 5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // loop error and pace
  input wire amh_pkg::amh_word_t follow_err,
  input wire logic slow,
  // encoder side
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic origin_sw,
  output int pos
);
  import amh_pkg::*;
  int cnt;
  int rem;
  // steps stay clear of the tick so the counter has caught up when the error is formed
  always_ff @(posedge aclk) begin
    cnt <= (!aresetn || cnt == SC - 1) ? 0 : cnt + 1;
    if (!aresetn) begin
      pos <= 0;
      rem <= 0;
    end else if (cnt == 4) begin
      rem <= $signed(follow_err);
    end else if (cnt > 4 && cnt < SC - 5 && cnt % (slow ? 6 : 3) == 2 && rem != 0) begin
      pos <= pos + (rem > 0 ? 1 : -1);
      rem <= rem - (rem > 0 ? 1 : -1);
    end
  end
  // gray order 00,01,11,10: square channels a quarter cycle apart
  assign enc_a = pos[1];
  assign enc_b = pos[1] ^ pos[0];
  assign origin_sw = pos >= ORG;
  assign enc_index = ((pos % IPER) + IPER) % IPER == IOFF;
endmodule

// ### sim/tb.sv
// self-checking bench for the axis sequencer: moves, jog, limits, home search
`timescale 1ns/1ps
`include "amh_defs.svh"
module tb;
  import amh_pkg::*;
  localparam int SC = 40;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, bres, rres;
  logic [3:0] wstrb = 4'hf;
  amh_word_t wdata = 0, rdata, follow_err, d0, d1, d2;
  logic jog_fwd = 0, jog_rev = 0, jog_fast = 0, slow = 0, o;
  logic enc_a, enc_b, enc_index, origin_sw, busy, home_done, disp_suppress;
  logic saw_e = 0, back_e = 0;
  int pos, prev, p0, t, n, exp_d, err_count = 0, checked = 0, cyc = 0;
  integer seed = 49187;
  logic [7:0] radr [9] = '{`AMH_OFF_VEL, `AMH_OFF_ACC, `AMH_OFF_JOG_HI, `AMH_OFF_JOG_LO,
    `AMH_OFF_HOME_VEL, `AMH_OFF_LIM_LO, `AMH_OFF_LIM_HI, `AMH_OFF_POS, `AMH_OFF_STATUS};
  amh_word_t rval [9] = '{`AMH_RST_VEL, `AMH_RST_ACC, `AMH_RST_JOG_HI, `AMH_RST_JOG_LO,
    `AMH_RST_HOME_VEL, `AMH_RST_LIM_LO, `AMH_RST_LIM_HI, 32'h0000_0000, 32'h0000_0000};

  amh_axis_seq #(.SERVO_CYCLES(SC)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .enc_a, .enc_b, .enc_index, .origin_sw,
    .jog_fwd, .jog_rev, .jog_fast, .follow_err, .busy, .home_done, .disp_suppress);
  amh_enc_model #(.SC(SC)) enc (.aclk, .aresetn, .follow_err, .slow, .enc_a, .enc_b,
    .enc_index, .origin_sw, .pos);

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // watchdog and segment-e watcher
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev <= pos;
    if (disp_suppress === 1'b1 && busy === 1'b1) begin
      saw_e <= 1;
      if (pos < prev) back_e <= 1;
    end
    if (cyc == 90000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input amh_word_t got, input amh_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input amh_word_t d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      k++;
    end while (bvalid !== 1'b1 && k < 40);
    if (bvalid !== 1'b1) err_count++;
    bres = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output amh_word_t d);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
      k++;
    end while (rvalid !== 1'b1 && k < 40);
    if (rvalid !== 1'b1) err_count++;
    d = rdata;
    rres = rresp;
    rready <= 0;
  endtask

  // reads at a fixed phase of the servo period, so differences are per-tick steps
  task automatic rd_at(input int w, output amh_word_t d);
    while (cyc < w) @(posedge aclk);
    rd(`AMH_OFF_DPOS, d);
  endtask

  task automatic idle();
    int k;
    k = 0;
    repeat (3) @(posedge aclk);
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    repeat (2 * SC) @(posedge aclk);
    while (follow_err !== 32'h0000_0000 && k < 30000) begin
      @(posedge aclk);
      k++;
    end
    if (busy !== 1'b0 || follow_err !== 32'h0000_0000) err_count++;
  endtask

  task automatic mv(input amh_word_t tgt, input logic rel);
    wr(`AMH_OFF_TARGET, tgt);
    wr(`AMH_OFF_CTRL, {30'h0000_0000, rel, 1'b1});
    idle();
  endtask

  function automatic int first_idx(input int org);
    return org + (((5 - org) % 64) + 64) % 64;
  endfunction

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    foreach (radr[i]) begin
      rd(radr[i], d0);
      chk(d0, rval[i]);
    end
    rd(8'h40, d0);
    chk({d0[29:0], rres}, {30'h0000_0000, `AMH_RESP_SLVERR});
    wr(8'h44, 32'h0000_0001);
    chk(bres, `AMH_RESP_SLVERR);
    wr(`AMH_OFF_VEL, 8);
    wr(`AMH_OFF_ACC, 4);
    exp_d = 0;
    for (int i = 0; i < 4; i++) begin
      t = ($random(seed) & 32'h0000_00ff) - 128;
      slow <= i[1];
      exp_d = i[0] ? exp_d + t : t;
      mv(t, i[0]);
      rd(`AMH_OFF_DPOS, d0);
      chk(d0, exp_d);
      rd(`AMH_OFF_POS, d1);
      chk(d1, pos);
      rd(`AMH_OFF_FERR, d2);
      chk(d2, d0 - d1);
    end
    slow <= 0;
    wr(`AMH_OFF_ACC, 1000);
    wr(`AMH_OFF_TARGET, exp_d + 2000);
    wr(`AMH_OFF_CTRL, 1);
    t = cyc + 3 * SC;
    rd_at(t, d0);
    rd_at(t + SC, d1);
    chk(d1 - d0, 8);
    wr(`AMH_OFF_VEL, 5);
    t = cyc + SC;
    rd_at(t, d0);
    rd_at(t + SC, d1);
    chk(d1 - d0, 5);
    wr(`AMH_OFF_LIM_HI, d1 + 60);
    idle();
    rd(`AMH_OFF_STATUS, d2);
    chk(d2[6], 1);
    rd(`AMH_OFF_DPOS, d0);
    chk($signed(d0) <= $signed(d1 + 60), 1);
    wr(`AMH_OFF_LIM_HI, 32'h7FFF_FFFF);
    wr(`AMH_OFF_ACC, 30);
    wr(`AMH_OFF_JOG_LO, 7);
    jog_fast <= 1;
    jog_fwd <= 1;
    t = cyc + SC;
    rd_at(t, d0);
    rd_at(t + SC, d1);
    rd_at(t + 2 * SC, d2);
    chk((d2 - d1) - (d1 - d0), 3);
    jog_fwd <= 0;
    // jog buttons are not registered: state and busy each add one edge
    repeat (4) @(posedge aclk);
    chk(busy, 0);
    t = cyc + SC;
    rd_at(t, d0);
    rd_at(t + SC, d1);
    chk(d1 - d0, 0);
    wr(`AMH_OFF_ACC, 1000);
    jog_fast <= 0;
    jog_rev <= 1;
    t = cyc + 2 * SC;
    rd_at(t, d0);
    rd_at(t + SC, d1);
    chk(d1 - d0, -7);
    jog_rev <= 0;
    wr(`AMH_OFF_ACC, 10);
    idle();
    wr(`AMH_OFF_HOME_VEL, 20);
    for (int k = 0; k < 2; k++) begin
      mv(k ? -150 : 320, 0);
      p0 = pos;
      o = origin_sw;
      // nothing else is sent while the search runs
      wr(`AMH_OFF_CTRL, 4);
      n = 0;
      while (pos == p0 && n < 3000) begin
        @(posedge aclk);
        n++;
      end
      chk(pos < p0, o);
      idle();
      chk(home_done, 1);
      rd(`AMH_OFF_STATUS, d0);
      chk(d0[5:0], 6'h20);
      rd(`AMH_OFF_POS, d1);
      chk(d1, 0);
      chk(pos, first_idx(200));
    end
    chk(saw_e, 1);
    chk(back_e, 0);
    test_done();
  end
endmodule
